// *** afg_top.v ***
// Amplifier control block: AXI4-Lite registers, fault flag, gain decode and power control
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "afg_map.vh"

module afg_top (
	aclk,
	aresetn,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	fault_short_in,
	fault_open_in,
	fault_rail_in,
	fault_ovc_in,
	fault_therm_in,
	fault_n_o,
	fault_n_oe,
	out_stage_en,
	power_on,
	in1_sel,
	in2_sel,
	ilimit_supply,
	diag_enable,
	diag_continuous,
	gain1_half_db,
	gain2_half_db,
	irq
);

	input wire aclk;
	input wire aresetn;
	input wire [`AFG_ADDR_W-1:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [`AFG_ADDR_W-1:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;
	input wire fault_short_in;
	input wire fault_open_in;
	input wire fault_rail_in;
	input wire fault_ovc_in;
	input wire fault_therm_in;
	output wire fault_n_o;
	output wire fault_n_oe;
	output reg out_stage_en;
	output wire power_on;
	output wire in1_sel;
	output wire in2_sel;
	output wire ilimit_supply;
	output wire diag_enable;
	output wire diag_continuous;
	output reg signed [`AFG_DB_W-1:0] gain1_half_db;
	output reg signed [`AFG_DB_W-1:0] gain2_half_db;
	output wire irq;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [4:0] mode_r;
	reg [4:0] diag_r;
	reg [`AFG_NFLT-1:0] mask_r;
	reg [`AFG_GAIN_W-1:0] gain1_r;
	reg [`AFG_GAIN_W-1:0] gain2_r;
	reg [`AFG_NIRQ-1:0] irq_stat_r;
	reg [`AFG_NIRQ-1:0] irq_mask_r;
	reg [`AFG_NFLT-1:0] det_s1_r;
	reg [`AFG_NFLT-1:0] det_s2_r;
	reg aw_hold_r;
	reg w_hold_r;
	reg [`AFG_ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	wire fault_latched;
	wire prot_latched;
	wire [`AFG_NFLT-1:0] fault_src;
	wire clear_pulse;
	wire fault_set_pulse;
	wire signed [`AFG_DB_W-1:0] g1_dec;
	wire signed [`AFG_DB_W-1:0] g2_dec;
	wire [`AFG_NFLT-1:0] det_raw;
	wire wr_go;
	wire [`AFG_NIRQ-1:0] irq_evt;
	wire [31:0] rd_val;
	wire rd_ok;
	wire irq_wr;

	function [31:0] afg_rd;
		input [`AFG_ADDR_W-1:0] a;
		begin
			case (a[`AFG_ADDR_W-1:2])
				`AFG_OFF_MODE: afg_rd = {27'h0, mode_r};
				`AFG_OFF_DIAG: afg_rd = {27'h0, diag_r};
				`AFG_OFF_MASK: afg_rd = {27'h0, mask_r};
				`AFG_OFF_GAIN1: afg_rd = {27'h0, gain1_r};
				`AFG_OFF_GAIN2: afg_rd = {27'h0, gain2_r};
				`AFG_OFF_IRQ_STAT: afg_rd = {30'h0, irq_stat_r};
				`AFG_OFF_IRQ_MASK: afg_rd = {30'h0, irq_mask_r};
				`AFG_OFF_STATUS: afg_rd = {25'h0, fault_src, prot_latched, fault_latched};
				default: afg_rd = 32'h0;
			endcase
		end
	endfunction

	function afg_mapped;
		input [`AFG_ADDR_W-1:0] a;
		begin
			afg_mapped = (a[`AFG_ADDR_W-1:2] <= `AFG_OFF_STATUS);
		end
	endfunction

	// ----------------------------------------
	// Fault detector inputs
	// ----------------------------------------
	// Analog detectors are asynchronous to aclk; two flops before use
	// A detector level shorter than one clock may be missed
	assign det_raw = {fault_therm_in, fault_ovc_in, fault_rail_in, fault_open_in, fault_short_in};

	always @(posedge aclk) begin
		if (!aresetn) begin
			det_s1_r <= {`AFG_NFLT{1'b0}};
			det_s2_r <= {`AFG_NFLT{1'b0}};
		end else begin
			det_s1_r <= det_raw;
			det_s2_r <= det_s1_r;
		end
	end

	// ----------------------------------------
	// Fault latch and flag pin
	// ----------------------------------------
	afg_fault_ctl u_fault (
		.aclk(aclk),
		.aresetn(aresetn),
		.fault_det(det_s2_r),
		.fault_mask(mask_r),
		.diag_fault_clear(diag_r[`AFG_DIAG_CLR]),
		.fault_latched_r(fault_latched),
		.prot_latched_r(prot_latched),
		.fault_src_r(fault_src),
		.clear_pulse(clear_pulse),
		.fault_set_pulse(fault_set_pulse)
	);

	// Open drain: data is always low, only the enable moves
	assign fault_n_o = 1'b0;
	assign fault_n_oe = fault_latched;

	// ----------------------------------------
	// Power and output stage
	// ----------------------------------------
	assign power_on = mode_r[`AFG_MODE_PWR];
	assign in1_sel = mode_r[`AFG_MODE_IN1];
	assign in2_sel = mode_r[`AFG_MODE_IN2];
	assign ilimit_supply = diag_r[`AFG_DIAG_ILIM];
	assign diag_enable = diag_r[`AFG_DIAG_EN];
	assign diag_continuous = diag_r[`AFG_DIAG_CONT];

	// Gains are registered, so a new code shows one clock after it is written
	// Live thermal input also cuts the stage the same cycle the latch sets
	always @(posedge aclk) begin
		if (!aresetn) begin
			out_stage_en <= 1'b0;
			gain1_half_db <= `AFG_GAIN_DB_RST;
			gain2_half_db <= `AFG_GAIN_DB_RST;
		end else begin
			out_stage_en <= power_on & ~prot_latched & ~det_s2_r[`AFG_FLT_THERM];
			gain1_half_db <= g1_dec;
			gain2_half_db <= g2_dec;
		end
	end

	afg_gain_dec u_g1 (
		.code(gain1_r),
		.half_db(g1_dec)
	);

	afg_gain_dec u_g2 (
		.code(gain2_r),
		.half_db(g2_dec)
	);

	// ----------------------------------------
	// AXI4-Lite write
	// ----------------------------------------
	assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
	// Address and data are held apart, so either may arrive first
	assign wr_go = aw_hold_r & w_hold_r;
	assign irq_evt = {clear_pulse & fault_latched, fault_set_pulse};
	assign irq = |(irq_stat_r & irq_mask_r);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= {`AFG_ADDR_W{1'b0}};
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			mode_r <= `AFG_MODE_RST;
			diag_r <= `AFG_DIAG_RST;
			mask_r <= `AFG_MASK_RST;
			gain1_r <= `AFG_GAIN_RST;
			gain2_r <= `AFG_GAIN_RST;
			irq_mask_r <= {`AFG_NIRQ{1'b0}};
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= afg_mapped(awaddr_r) ? 2'h0 : 2'h2;
				if (wstrb_r[0]) begin
					case (awaddr_r[`AFG_ADDR_W-1:2])
						`AFG_OFF_MODE: mode_r <= wdata_r[4:0];
						`AFG_OFF_DIAG: diag_r <= wdata_r[4:0];
						`AFG_OFF_MASK: mask_r <= wdata_r[4:0];
						`AFG_OFF_GAIN1: gain1_r <= wdata_r[4:0];
						`AFG_OFF_GAIN2: gain2_r <= wdata_r[4:0];
						`AFG_OFF_IRQ_MASK: irq_mask_r <= wdata_r[1:0];
						default: mode_r <= mode_r;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Write-one-clear and a new event in one cycle: the event wins so no fault goes unreported
	assign irq_wr = wr_go & wstrb_r[0] & (awaddr_r[`AFG_ADDR_W-1:2] == `AFG_OFF_IRQ_STAT);

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= {`AFG_NIRQ{1'b0}};
		end else if (irq_wr) begin
			irq_stat_r <= (irq_stat_r & ~wdata_r[`AFG_NIRQ-1:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read
	// ----------------------------------------
	// One read in flight: arready stays low until the data is taken
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_val = afg_rd(s_axi_araddr);
	assign rd_ok = afg_mapped(s_axi_araddr);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // afg_top

// *** afg_map.vh ***
// Register map, field positions and constants for the amplifier fault, gain and power control block
`ifndef AFG_MAP_VH
`define AFG_MAP_VH

// ----------------------------------------
// Register word index (byte address is four times the index)
// ----------------------------------------
`define AFG_OFF_MODE 3'h0
`define AFG_OFF_DIAG 3'h1
`define AFG_OFF_MASK 3'h2
`define AFG_OFF_GAIN1 3'h3
`define AFG_OFF_GAIN2 3'h4
`define AFG_OFF_IRQ_STAT 3'h5
`define AFG_OFF_IRQ_MASK 3'h6
`define AFG_OFF_STATUS 3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFG_MODE_IN1 2
`define AFG_MODE_IN2 3
`define AFG_MODE_PWR 4
`define AFG_DIAG_ILIM 1
`define AFG_DIAG_CLR 2
`define AFG_DIAG_CONT 3
`define AFG_DIAG_EN 4
`define AFG_FLT_SHORT 0
`define AFG_FLT_OPEN 1
`define AFG_FLT_RAIL 2
`define AFG_FLT_OVC 3
`define AFG_FLT_THERM 4
`define AFG_IRQ_FAULT 0
`define AFG_IRQ_CLEARED 1

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define AFG_NFLT 5
`define AFG_GAIN_W 5
`define AFG_DB_W 9
`define AFG_GAIN_DB_RST (-9'sd160)
`define AFG_NIRQ 2
`define AFG_MODE_RST 5'h00
`define AFG_DIAG_RST 5'h00
`define AFG_MASK_RST 5'h00
`define AFG_GAIN_RST 5'h00
`define AFG_ADDR_W 5

`endif

// *** afg_gain_dec.v ***
// Gain code to signed half-dB decoder for one input path
`timescale 1ns/100ps
`include "afg_map.vh"

module afg_gain_dec (
	input wire [`AFG_GAIN_W-1:0] code,
	output reg signed [`AFG_DB_W-1:0] half_db
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Gain in units of 0.5 dB so every table entry is an integer; -80 dB needs nine signed bits
	always @* begin
		case (code)
			5'h00: half_db = -9'sd160;
			5'h01: half_db = -9'sd108;
			5'h02: half_db = -9'sd81;
			5'h03: half_db = -9'sd69;
			5'h04: half_db = -9'sd60;
			5'h05: half_db = -9'sd54;
			5'h06: half_db = -9'sd48;
			5'h07: half_db = -9'sd42;
			5'h08: half_db = -9'sd36;
			5'h09: half_db = -9'sd30;
			default: half_db = $signed({4'h0, code}) * 9'sd3 - 9'sd57;
		endcase
	end

endmodule // afg_gain_dec

// *** afg_fault_ctl.v ***
// Fault latch, protection latch and clear-toggle detection
`timescale 1ns/100ps
`include "afg_map.vh"

module afg_fault_ctl (
	input wire aclk,
	input wire aresetn,
	input wire [`AFG_NFLT-1:0] fault_det,
	input wire [`AFG_NFLT-1:0] fault_mask,
	input wire diag_fault_clear,
	output reg fault_latched_r,
	output reg prot_latched_r,
	output reg [`AFG_NFLT-1:0] fault_src_r,
	output wire clear_pulse,
	output wire fault_set_pulse
);

	reg clr_prev_r;
	wire [`AFG_NFLT-1:0] flag_hit;
	wire prot_hit;

	assign flag_hit = fault_det & ~fault_mask;
	assign prot_hit = |fault_det;
	// Any edge of the clear bit counts as a toggle
	assign clear_pulse = diag_fault_clear ^ clr_prev_r;
	assign fault_set_pulse = (|flag_hit) & ~fault_latched_r;

	// ----------------------------------------
	// Latches
	// ----------------------------------------
	// A fault in the clearing cycle wins, so an ongoing fault cannot be cleared away
	always @(posedge aclk) begin
		if (!aresetn) begin
			clr_prev_r <= 1'b0;
			fault_latched_r <= 1'b0;
			prot_latched_r <= 1'b0;
			fault_src_r <= {`AFG_NFLT{1'b0}};
		end else begin
			clr_prev_r <= diag_fault_clear;
			if (|flag_hit) begin
				fault_latched_r <= 1'b1;
			end else if (clear_pulse) begin
				fault_latched_r <= 1'b0;
			end
			if (prot_hit) begin
				prot_latched_r <= 1'b1;
			end else if (clear_pulse) begin
				prot_latched_r <= 1'b0;
			end
			if (clear_pulse && !prot_hit) begin
				fault_src_r <= {`AFG_NFLT{1'b0}};
			end else begin
				fault_src_r <= fault_src_r | fault_det;
			end
		end
	end

endmodule // afg_fault_ctl

// *** afg_monitor.sv ***
// Port checker for fault flag, gain and power behaviour
`timescale 1ns/100ps
`include "afg_map.vh"
module afg_monitor (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire fault_short_in,
	input wire fault_open_in,
	input wire fault_rail_in,
	input wire fault_ovc_in,
	input wire fault_therm_in,
	input wire fault_n_o,
	input wire fault_n_oe,
	input wire out_stage_en,
	input wire power_on,
	input wire signed [`AFG_DB_W-1:0] gain1_half_db
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire any_flt = fault_short_in | fault_open_in | fault_rail_in | fault_ovc_in | fault_therm_in;
	a_pin_never_high: assert property (fault_n_o == 1'b0) else $error("fault pin driven high");
	a_flag_has_cause: assert property ($rose(fault_n_oe) |-> $past(any_flt, 3))
		else $error("flag without detector");
	a_flag_stays_low: assert property (fault_n_oe && !s_axi_bvalid && !$past(s_axi_bvalid) |=> fault_n_oe)
		else $error("flag released without write");
	a_release_after_write: assert property ($fell(fault_n_oe) |-> $past(s_axi_bvalid))
		else $error("flag released unprompted");
	a_therm_stops_out: assert property (fault_therm_in [*4] |=> !out_stage_en)
		else $error("output on in overheat");
	a_masked_still_prot: assert property (fault_short_in [*5] |=> !out_stage_en)
		else $error("output on during short");
	a_prot_with_flag: assert property (fault_n_oe && $past(fault_n_oe) |-> !out_stage_en)
		else $error("output on while flagged");
	// The decoded gain is registered one clock behind the code, one clock after the response is raised
	a_gain_on_write: assert property ($changed(gain1_half_db) |-> $past(s_axi_bvalid))
		else $error("gain moved without write");
	a_power_on_write: assert property ($changed(power_on) |-> s_axi_bvalid)
		else $error("power moved without write");
	cover property ($fell(fault_n_oe));
	cover property ($rose(out_stage_en));
	cover property ($changed(gain1_half_db));
endmodule // afg_monitor

bind afg_top afg_monitor i_afg_monitor (.aclk, .aresetn, .s_axi_bvalid, .fault_short_in, .fault_open_in,
	.fault_rail_in, .fault_ovc_in, .fault_therm_in, .fault_n_o, .fault_n_oe, .out_stage_en, .power_on,
	.gain1_half_db);

// *** afg_host_mdl.sv ***
// Host side of the fault line: pull-up and open-drain wire
`timescale 1ns/100ps
module afg_host_mdl (
	input wire fault_n_o,
	input wire fault_n_oe,
	output wire fault_line
);
	// Pull-up holds the line high whenever the block does not sink it
	assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
endmodule // afg_host_mdl

// *** tb_top.sv ***
// Self-checking bench for the amplifier control block
`timescale 1ns/100ps
`include "afg_map.vh"
module tb_top;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00, flt = 5'h00, dg = 5'h00;
	reg [31:0] s_axi_wdata = 32'h0, rd;
	reg [1:0] br, rr;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_n_o, fault_n_oe;
	wire out_stage_en, power_on, in1_sel, in2_sel, ilimit_supply, diag_enable, diag_continuous, irq, fault_line;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire signed [8:0] gain1_half_db, gain2_half_db;
	integer fails = 0, num_checks = 0, i;

	always #10 aclk = ~aclk;

	afg_top i_afg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.fault_short_in(flt[0]), .fault_open_in(flt[1]), .fault_rail_in(flt[2]), .fault_ovc_in(flt[3]),
		.fault_therm_in(flt[4]), .fault_n_o, .fault_n_oe, .out_stage_en, .power_on, .in1_sel, .in2_sel,
		.ilimit_supply, .diag_enable, .diag_continuous, .gain1_half_db, .gain2_half_db, .irq);
	afg_host_mdl i_afg_host_mdl (.fault_n_o, .fault_n_oe, .fault_line);

	// ----
	// Helpers
	// ----
	task chk(input [31:0] s, input [31:0] e, input [63:0] n);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				fails = fails + 1;
				$display("Error %0s expected %h seen %h", n, e, s);
			end
		end
	endtask

	task give_verdict;
		begin
			if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask

	task wr(input [4:0] a, input [31:0] d);
		reg ap, wp, ta, tw;
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			ap = 1;
			wp = 1;
			while (ap || wp) begin
				@(negedge aclk);
				ta = ap & s_axi_awready;
				tw = wp & s_axi_wready;
				@(posedge aclk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
				ap = ap & !ta;
				wp = wp & !tw;
			end
			ta = 0;
			while (!ta) begin
				@(negedge aclk);
				ta = s_axi_bvalid;
				br = s_axi_bresp;
				@(posedge aclk);
			end
			s_axi_bready <= 1'b0;
		end
	endtask

	task rdr(input [4:0] a);
		reg rv;
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			rv = 0;
			while (!rv) begin
				@(negedge aclk);
				rv = s_axi_arready;
				@(posedge aclk);
			end
			s_axi_arvalid <= 1'b0;
			rv = 0;
			while (!rv) begin
				@(negedge aclk);
				rv = s_axi_rvalid;
				rd = s_axi_rdata;
				rr = s_axi_rresp;
				@(posedge aclk);
			end
			s_axi_rready <= 1'b0;
		end
	endtask

	function signed [8:0] gexp(input integer c);
		begin
			case (c)
				0: gexp = -160;
				1: gexp = -108;
				2: gexp = -81;
				3: gexp = -69;
				4: gexp = -60;
				5: gexp = -54;
				6: gexp = -48;
				7: gexp = -42;
				8: gexp = -36;
				9: gexp = -30;
				default: gexp = 3 * c - 57;
			endcase
		end
	endfunction

	// Toggling rather than setting the clear bit is what releases the flag
	task clear_flag;
		begin
			dg = dg ^ 5'h04;
			wr(5'h04, dg);
			repeat (3) @(posedge aclk);
			@(negedge aclk);
		end
	endtask

	task pulse_fault(input [4:0] v);
		begin
			@(posedge aclk);
			flt <= v;
			repeat (6) @(posedge aclk);
			flt <= 5'h00;
			@(negedge aclk);
		end
	endtask

	// ----
	// Scenarios
	// ----
	task t_gain;
		begin
			for (i = 0; i < 32; i = i + 1) begin
				wr(5'h0C, i);
				wr(5'h10, 31 - i);
				@(negedge aclk);
				chk(gain1_half_db, gexp(i), "gain1");
				chk(gain2_half_db, gexp(31 - i), "gain2");
			end
		end
	endtask

	task t_fault;
		begin
			wr(5'h00, 32'h1C);
			@(negedge aclk);
			chk(power_on, 1, "pwr_on");
			chk(in1_sel, 1, "in1");
			chk(in2_sel, 1, "in2");
			wr(5'h18, 32'h1);
			for (i = 0; i < 5; i = i + 1) begin
				pulse_fault(5'h01 << i);
				chk(fault_line, 0, "flag");
				chk(out_stage_en, 0, "out_en");
				repeat (20) @(posedge aclk);
				@(negedge aclk);
				chk(fault_line, 0, "latched");
				rdr(5'h1C);
				chk(rd, (32'h1 << (i + 2)) | 32'h3, "status");
				chk(irq, 1, "irq");
				wr(5'h18, 32'h0);
				@(negedge aclk);
				chk(irq, 0, "irq_msk");
				wr(5'h18, 32'h1);
				clear_flag;
				chk(fault_line, 1, "cleared");
				chk(out_stage_en, 1, "restore");
				wr(5'h14, 32'h3);
				@(negedge aclk);
				chk(irq, 0, "irq_clr");
			end
			rdr(5'h04);
			chk(rd, dg, "diag_rd");
			chk(rr, 0, "rresp");
			chk(br, 0, "bresp");
		end
	endtask

	task t_mask;
		begin
			wr(5'h08, 32'h1);
			pulse_fault(5'h01);
			chk(fault_line, 1, "masked");
			chk(out_stage_en, 0, "m_prot");
			clear_flag;
			pulse_fault(5'h10);
			chk(out_stage_en, 0, "therm");
			chk(fault_line, 0, "t_flag");
			clear_flag;
			wr(5'h00, 32'h0);
			@(negedge aclk);
			chk(power_on, 0, "pwr_off");
			// Keeps the clear bit as it is, so no release toggle is sent
			dg = dg | 5'h1A;
			wr(5'h04, dg);
			@(negedge aclk);
			chk(ilimit_supply, 1, "ilim");
			chk(diag_continuous, 1, "d_cont");
			chk(diag_enable, 1, "d_en");
		end
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(fault_line, 1, "rst_flag");
		chk(gain1_half_db, -160, "rst_gain");
		t_gain;
		t_fault;
		t_mask;
		give_verdict;
	end

	initial begin
		#400000;
		fails = fails + 1;
		give_verdict;
	end
endmodule // tb_top
